// [bxy_cfg.svh]
// constants for the coordinate blit command issuer
`ifndef BXY_CFG_SVH
`define BXY_CFG_SVH
// own register offsets (byte addresses)
`define BXY_OFF_CTRL 8'h00
`define BXY_OFF_STATUS 8'h04
`define BXY_OFF_OPT 8'h08
`define BXY_OFF_CNT 8'h0C
`define BXY_OFF_SLOT0 8'h10
`define BXY_NSLOT 20
`define BXY_FIRST_DATA 5'h0C
`define BXY_MAX_INLINE 5'h08
// control register fields
`define BXY_CTRL_START 8
// header layout
`define BXY_CLIENT_2D 3'h2
`define BXY_HDR_MASK_HI 21
`define BXY_HDR_MASK_LO 20
`define BXY_HDR_PACK 16
`define BXY_HDR_TILE 11
// opcodes
`define BXY_OP_SETUP 7'h01
`define BXY_OP_MONO 7'h11
`define BXY_OP_CLIP 7'h03
`define BXY_OP_PIXEL 7'h24
`define BXY_OP_SCAN 7'h25
`define BXY_OP_TEXT 7'h26
`define BXY_OP_INLINE 7'h31
// length fields
`define BXY_LEN_SETUP 8'h06
`define BXY_LEN_MONO 8'h07
`define BXY_LEN_CLIP 8'h01
`define BXY_LEN_PIXEL 8'h00
`define BXY_LEN_SCAN 8'h01
`define BXY_LEN_TEXT 8'h02
`define BXY_LEN_INLINE 8'h01
// field masks
`define BXY_CLIP_MASK 32'h7FFF_7FFF
`define BXY_PAT_MASK 32'h07FF_FFC0
`define BXY_TILE_ALIGN 32'h0000_0FFF
`define BXY_PITCH_SIGN 15
`endif

// [bxy_pkg.sv]
// types for the coordinate blit command issuer
package bxy_pkg;
  // command kinds selectable by software
  typedef enum logic [2:0] {
    BXY_K_SETUP, BXY_K_MONO, BXY_K_CLIP, BXY_K_PIXEL, BXY_K_SCAN, BXY_K_TEXT, BXY_K_INLINE, BXY_K_BAD
  } bxy_kind_t;
  // one double word toward the command streamer
  typedef struct packed {
    logic valid;
    logic last;
    logic [31:0] data;
  } bxy_word_t;
endpackage

// [bxy_issuer.sv]
// command issuer that builds and streams coordinate blit packets
// Notes on behaviour
// RULE1 - header top bits carry 2D client code
// RULE2 - mono setup: opcode 11h, length 07h
// RULE3 - clip setup: opcode 03h, two clip words
// RULE4 - pixel draw: opcode 24h, one coordinate word
// RULE5 - scanline draw: opcode 25h, seeds in header
// RULE6 - text draw: opcode 26h, packing bit 16
// RULE7 - inline text: opcode 31h, data in stream
// RULE8 - device decodes color depth field bits 25:24
// RULE9 - clip coordinates are 15-bit positive fields
// RULE10 - device treats destination coordinates as signed
// RULE11 - device clips and writes single pixel
// RULE12 - device pattern index is coordinate plus seed
// RULE13 - device writes only inside clip and range (model: scanline tests the clip columns only, not top/bottom)
// RULE14 - device steps text lines by bit/byte
// RULE15 - no negative pitch for pixel or text
// RULE16 - inline data word count must be even
// RULE17 - device scales tiled pitch granularity
// RULE18 - tiled destination base aligned to 4K
// RULE19 - device honours solid and transparency bits
// RULE20 - device takes color width by depth
// RULE21 - device holds mono pattern low then high
// RULE22 - pattern base keeps only bits 26:6
// RULE23 - device keeps setup state persistently
// RULE24 - device clip top/left inclusive, bottom/right exclusive
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "bxy_cfg.svh"
module bxy_issuer (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rd_data_q,
  output bxy_pkg::bxy_word_t cs_out_q,
  input wire logic cs_ready
);

  // issue engine states
  // idle: software may load slots, options and count
  // send: one packet leaves word by word, inputs frozen
  typedef enum logic {BXY_IDLE, BXY_SEND} bxy_state_t;

  bxy_state_t state_q; // engine state
  bxy_pkg::bxy_kind_t kind_q; // command being sent
  logic [31:0] slot_q [`BXY_NSLOT]; // parameter and inline data words
  logic [31:0] opt_q; // header option bits
  logic [4:0] cnt_q; // inline data word count
  logic [4:0] pos_q; // next word position in packet
  logic [4:0] total_q; // words in current packet
  logic pitch_neg_q; // last setup carried a negative pitch
  logic refused_q; // sticky: a start was refused
  logic err_pitch_q; // sticky: negative pitch cause
  logic err_align_q; // sticky: tiled base misaligned
  logic err_count_q; // sticky: bad inline count
  logic err_kind_q; // sticky: unknown kind

  // decode of the own register port; writes act at the strobe edge,
  // reads answer one cycle later and read zero otherwise
  // decoded start request
  logic start_req;
  bxy_pkg::bxy_kind_t req_kind;
  logic [4:0] slot_idx;
  logic slot_hit;
  logic bad_pitch, bad_align, bad_count, bad_kind, refuse;
  logic [4:0] req_total;
  logic [31:0] next_word;
  logic adv;
  logic status_clr;

  assign start_req = wr && (addr == `BXY_OFF_CTRL) && wdata[`BXY_CTRL_START];
  assign req_kind = bxy_pkg::bxy_kind_t'(wdata[2:0]);
  assign slot_hit = (addr >= `BXY_OFF_SLOT0) && (addr < (`BXY_OFF_SLOT0 + 8'(4 * `BXY_NSLOT)));
  assign slot_idx = 5'((addr - `BXY_OFF_SLOT0) >> 2);
  assign status_clr = wr && (addr == `BXY_OFF_STATUS);

  // packet word count, header included, per kind
  // the header length field is this count minus two;
  // an unknown kind gives zero and is refused before use
  function automatic logic [4:0] kind_total(input bxy_pkg::bxy_kind_t k, input logic [4:0] n);
    case (k)
      bxy_pkg::BXY_K_SETUP: kind_total = 5'(`BXY_LEN_SETUP) + 5'h02;
      bxy_pkg::BXY_K_MONO: kind_total = 5'(`BXY_LEN_MONO) + 5'h02; // RULE2
      bxy_pkg::BXY_K_CLIP: kind_total = 5'(`BXY_LEN_CLIP) + 5'h02; // RULE3
      bxy_pkg::BXY_K_PIXEL: kind_total = 5'(`BXY_LEN_PIXEL) + 5'h02; // RULE4
      bxy_pkg::BXY_K_SCAN: kind_total = 5'(`BXY_LEN_SCAN) + 5'h02; // RULE5
      bxy_pkg::BXY_K_TEXT: kind_total = 5'(`BXY_LEN_TEXT) + 5'h02; // RULE6
      bxy_pkg::BXY_K_INLINE: kind_total = 5'(`BXY_LEN_INLINE) + 5'h02 + n; // RULE7
      default: kind_total = 5'h00;
    endcase
  endfunction

  // slot that supplies body word idx of a packet
  // setup: control, clip pair, base, colors, pattern base
  // mono setup: as setup up to the colors, then pattern low and high
  // clip only: the clip pair
  // pixel: destination corner
  // scanline and text: destination corners, text adds source address
  // inline: destination corners, then the inline data slots
  function automatic logic [4:0] seq_slot(input bxy_pkg::bxy_kind_t k, input logic [4:0] idx);
    case (k)
      bxy_pkg::BXY_K_SETUP: seq_slot = idx;
      bxy_pkg::BXY_K_MONO: seq_slot = (idx < 5'h06) ? idx : idx + 5'h01; // RULE21
      bxy_pkg::BXY_K_CLIP: seq_slot = idx + 5'h01;
      bxy_pkg::BXY_K_PIXEL: seq_slot = idx + 5'h09;
      bxy_pkg::BXY_K_SCAN: seq_slot = idx + 5'h09;
      bxy_pkg::BXY_K_TEXT: seq_slot = idx + 5'h09;
      bxy_pkg::BXY_K_INLINE: seq_slot = (idx < 5'h02) ? idx + 5'h09 : idx + 5'h0A;
      default: seq_slot = 5'h00;
    endcase
  endfunction

  // header double word for a kind
  // only option bits that the kind defines are copied, the rest stay zero
  // so reserved header fields never carry stale option bits
  function automatic logic [31:0] header(input bxy_pkg::bxy_kind_t k, input logic [31:0] o,
                                         input logic [4:0] tot);
    logic [31:0] h;
    h = 32'h0000_0000;
    h[31:29] = `BXY_CLIENT_2D; // RULE1
    h[7:0] = 8'(tot) - 8'h02;
    h[`BXY_HDR_TILE] = o[`BXY_HDR_TILE];
    case (k)
      bxy_pkg::BXY_K_SETUP: begin
        h[28:22] = `BXY_OP_SETUP;
        h[`BXY_HDR_MASK_HI:`BXY_HDR_MASK_LO] = o[`BXY_HDR_MASK_HI:`BXY_HDR_MASK_LO];
      end
      bxy_pkg::BXY_K_MONO: begin
        h[28:22] = `BXY_OP_MONO; // RULE2
        h[`BXY_HDR_MASK_HI:`BXY_HDR_MASK_LO] = o[`BXY_HDR_MASK_HI:`BXY_HDR_MASK_LO];
      end
      bxy_pkg::BXY_K_CLIP: h[28:22] = `BXY_OP_CLIP; // RULE3
      bxy_pkg::BXY_K_PIXEL: h[28:22] = `BXY_OP_PIXEL; // RULE4
      bxy_pkg::BXY_K_SCAN: begin
        h[28:22] = `BXY_OP_SCAN; // RULE5
        h[14:12] = o[14:12]; // RULE5
        h[10:8] = o[10:8]; // RULE5
      end
      bxy_pkg::BXY_K_TEXT: begin
        h[28:22] = `BXY_OP_TEXT; // RULE6
        h[`BXY_HDR_PACK] = o[`BXY_HDR_PACK]; // RULE6
      end
      bxy_pkg::BXY_K_INLINE: begin
        h[28:22] = `BXY_OP_INLINE; // RULE7
        h[`BXY_HDR_PACK] = o[`BXY_HDR_PACK];
      end
      default: h[28:22] = 7'h00;
    endcase
    header = h;
  endfunction

  // checks applied when software asks for a packet
  // a refused start sends nothing and leaves a cause in the status register,
  // so the streamer never sees a packet the device could hang on
  always_comb begin
    bad_kind = (req_kind == bxy_pkg::BXY_K_BAD);
    // draws that rely on the stored pitch refuse a negative one
    bad_pitch = pitch_neg_q && ((req_kind == bxy_pkg::BXY_K_PIXEL) || (req_kind == bxy_pkg::BXY_K_TEXT) ||
                (req_kind == bxy_pkg::BXY_K_INLINE)); // RULE15
    // tiled setups need a 4K aligned destination base
    bad_align = opt_q[`BXY_HDR_TILE] && ((slot_q[3] & `BXY_TILE_ALIGN) != 32'h0000_0000) &&
                ((req_kind == bxy_pkg::BXY_K_SETUP) || (req_kind == bxy_pkg::BXY_K_MONO)); // RULE18
    // inline data must be an even, nonzero count that fits the buffer
    bad_count = (req_kind == bxy_pkg::BXY_K_INLINE) &&
                (cnt_q[0] || (cnt_q == 5'h00) || (cnt_q > `BXY_MAX_INLINE)); // RULE16
    refuse = bad_kind || bad_pitch || bad_align || bad_count;
    req_total = kind_total(req_kind, cnt_q);
  end

  // word at the current packet position, fields trimmed to legal bits
  // header is built on the fly from the latched kind and options;
  // clip words lose their sign bits, pattern base keeps its implemented bits
  always_comb begin
    logic [4:0] s;
    s = 5'h00;
    if (pos_q == 5'h00) begin
      next_word = header(kind_q, opt_q, total_q);
    end else begin
      s = seq_slot(kind_q, pos_q - 5'h01);
      next_word = slot_q[s];
      if ((s == 5'h01) || (s == 5'h02)) begin
        next_word = slot_q[s] & `BXY_CLIP_MASK; // RULE9
      end else if (s == 5'h06) begin
        next_word = slot_q[s] & `BXY_PAT_MASK; // RULE22
      end
    end
  end

  // stream may take a new word this cycle
  // the output register is free when empty or when its word is taken now,
  // so words leave back to back while the streamer keeps ready high
  assign adv = !cs_out_q.valid || cs_ready;

  // engine state and packet position
  // pos_q counts words handed to the output register; once it reaches
  // total_q the last word sits there and the engine waits until it is taken
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= BXY_IDLE;
      kind_q <= bxy_pkg::BXY_K_SETUP;
      pos_q <= 5'h00;
      total_q <= 5'h00;
    end else begin
      case (state_q)
        BXY_IDLE: begin
          // accepted start latches kind and length
          if (start_req && !refuse) begin
            state_q <= BXY_SEND;
            kind_q <= req_kind;
            pos_q <= 5'h00;
            total_q <= req_total;
          end
        end
        BXY_SEND: begin
          // last word handed out, return to idle
          if (adv) begin
            if (pos_q == total_q) begin
              state_q <= BXY_IDLE;
            end else begin
              pos_q <= pos_q + 5'h01;
            end
          end
        end
        default: state_q <= BXY_IDLE;
      endcase
    end
  end

  // output word register toward the streamer
  // a word stays put while the streamer stalls; it is never dropped
  // or replaced before the ready edge
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cs_out_q <= '0;
    end else if (adv) begin
      if ((state_q == BXY_SEND) && (pos_q != total_q)) begin
        cs_out_q.valid <= 1'b1;
        cs_out_q.data <= next_word;
        cs_out_q.last <= (pos_q == total_q - 5'h01);
      end else begin
        cs_out_q <= '0;
      end
    end
  end

  // parameter and inline data words, frozen while sending
  // writes while busy are ignored so a packet never mixes old and new words
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `BXY_NSLOT; i++) begin
        slot_q[i] <= 32'h0000_0000;
      end
    end else if (wr && slot_hit && (state_q == BXY_IDLE)) begin
      slot_q[slot_idx] <= wdata;
    end
  end

  // header options and inline count
  // also frozen while busy, for the same reason
  // the inline count is checked against the buffer depth at start
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      opt_q <= 32'h0000_0000;
      cnt_q <= 5'h00;
    end else if (wr && (state_q == BXY_IDLE)) begin
      if (addr == `BXY_OFF_OPT) begin
        opt_q <= wdata;
      end
      if (addr == `BXY_OFF_CNT) begin
        cnt_q <= wdata[4:0];
      end
    end
  end

  // pitch sign remembered from the last setup actually issued
  // a refused setup leaves the earlier sign in force, since the device
  // still holds the state of the last setup it received
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pitch_neg_q <= 1'b0;
    end else if (start_req && !refuse && (state_q == BXY_IDLE) &&
                 ((req_kind == bxy_pkg::BXY_K_SETUP) || (req_kind == bxy_pkg::BXY_K_MONO))) begin
      pitch_neg_q <= slot_q[0][`BXY_PITCH_SIGN]; // RULE15
    end
  end

  // sticky refusal flags, a new refusal beats a same-cycle clear
  // each cause bit clears only by writing one to it
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      refused_q <= 1'b0;
      err_pitch_q <= 1'b0;
      err_align_q <= 1'b0;
      err_count_q <= 1'b0;
      err_kind_q <= 1'b0;
    end else begin
      // clear by writing one
      if (status_clr) begin
        if (wdata[1]) refused_q <= 1'b0;
        if (wdata[2]) err_pitch_q <= 1'b0;
        if (wdata[3]) err_align_q <= 1'b0;
        if (wdata[4]) err_count_q <= 1'b0;
        if (wdata[5]) err_kind_q <= 1'b0;
      end
      // set on a refused start in idle
      if (start_req && refuse && (state_q == BXY_IDLE)) begin
        refused_q <= 1'b1;
        if (bad_pitch) err_pitch_q <= 1'b1; // RULE15
        if (bad_align) err_align_q <= 1'b1; // RULE18
        if (bad_count) err_count_q <= 1'b1; // RULE16
        if (bad_kind) err_kind_q <= 1'b1;
      end
    end
  end

  // read data, one cycle after the read strobe
  // zero in every other cycle so a stale value is never taken
  // for an answer
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rd_data_q <= 32'h0000_0000;
    end else if (rd) begin
      if (addr == `BXY_OFF_CTRL) begin
        rd_data_q <= {29'h000_0000, kind_q};
      end else if (addr == `BXY_OFF_STATUS) begin
        rd_data_q <= {25'h000_0000, pitch_neg_q, err_kind_q, err_count_q, err_align_q, err_pitch_q,
                      refused_q, (state_q == BXY_SEND)};
      end else if (addr == `BXY_OFF_OPT) begin
        rd_data_q <= opt_q;
      end else if (addr == `BXY_OFF_CNT) begin
        rd_data_q <= {27'h000_0000, cnt_q};
      end else if (slot_hit) begin
        rd_data_q <= slot_q[slot_idx];
      end else begin
        rd_data_q <= 32'h0000_0000;
      end
    end else begin
      rd_data_q <= 32'h0000_0000;
    end
  end

endmodule

// [bxy_monitor.sv]
// port checker for the coordinate blit command issuer
`timescale 1ns/1ps
module bxy_monitor (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic rd,
  input wire logic [31:0] rd_data_q,
  input wire bxy_pkg::bxy_word_t cs_out_q,
  input wire logic cs_ready
);
  logic first_q; // next word taken is a header
  logic [6:0] op_q; // opcode of packet in flight
  logic [7:0] len_q; // length field of packet in flight
  logic [7:0] cnt_q; // words taken so far
  wire take = cs_out_q.valid && cs_ready; // word taken this edge
  wire [6:0] op = cs_out_q.data[28:22]; // opcode on the stream
  wire [7:0] len = cs_out_q.data[7:0]; // length on the stream
  // track position inside the packet
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      first_q <= 1'b1;
      op_q <= 7'h00;
      len_q <= 8'h00;
      cnt_q <= 8'h00;
    end else if (take) begin
      first_q <= cs_out_q.last;
      cnt_q <= first_q ? 8'h01 : cnt_q + 8'h01;
      if (first_q) begin
        op_q <= op;
        len_q <= len;
      end
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  rd_answer_a: assert property (!$past(rd) |-> rd_data_q == 32'h0000_0000) else $error("stray read data");
  word_hold_a: assert property (cs_out_q.valid && !cs_ready |=> cs_out_q.valid && $stable(cs_out_q.data))
    else $error("word changed before taken");
  client_code_a: assert property (cs_out_q.valid && first_q |-> cs_out_q.data[31:29] == 3'h2)
    else $error("bad client code");
  setup_len_a: assert property (cs_out_q.valid && first_q && op inside {7'h01, 7'h11}
    |-> len == ((op == 7'h11) ? 8'h07 : 8'h06)) else $error("bad setup length");
  draw_len_a: assert property (cs_out_q.valid && first_q && op inside {7'h03, 7'h24, 7'h25, 7'h26}
    |-> len == ((op == 7'h24) ? 8'h00 : (op == 7'h26) ? 8'h02 : 8'h01)) else $error("bad draw length");
  inline_even_a: assert property (cs_out_q.valid && first_q && op == 7'h31
    |-> len[0] && len >= 8'h03 && len <= 8'h09) else $error("odd inline count");
  pkt_length_a: assert property (cs_out_q.valid && cs_out_q.last |-> !first_q && cnt_q == len_q + 8'h01)
    else $error("packet length mismatch");
  clip_mask_a: assert property (cs_out_q.valid && !first_q && op_q == 7'h03
    |-> (cs_out_q.data & 32'h8000_8000) == 32'h0000_0000) else $error("clip word not masked");
  pixel_short_a: assert property (take && first_q && op == 7'h24 |=> cs_out_q.valid && cs_out_q.last)
    else $error("pixel packet not two words");
endmodule
bind bxy_issuer bxy_monitor mon (.mclk(mclk), .rstn(rstn), .rd(rd), .rd_data_q(rd_data_q),
  .cs_out_q(cs_out_q), .cs_ready(cs_ready));

// [bxy_far.sv]
// command streamer side model that takes and records packets
`timescale 1ns/1ps
module bxy_far (
  input wire logic mclk,
  input wire logic rstn,
  input wire bxy_pkg::bxy_word_t cs_in,
  input wire logic slow,
  output logic cs_ready
);
  logic [31:0] words [0:15]; // words of the last packet
  int nw; // words of current packet
  int npk; // packets routed to the blitter
  logic first; // next word is a header
  logic routed; // header names the 2D client
  logic [6:0] hop; // opcode of current packet
  logic [31:0] setup_ctrl; // persistent setup control copy
  logic [31:0] clip_tl; // persistent clip top-left
  logic [31:0] clip_br; // persistent clip bottom-right
  logic [31:0] dest_base; // persistent destination base
  logic [31:0] fg_color; // persistent foreground color
  logic [63:0] mono_pat; // 8x8 mono pattern, low word first
  logic [31:0] pix_addr; // address of last pixel written
  logic [31:0] pix_val; // color of last pixel written
  logic src_keep_bg; // text background written
  int px; // signed destination x of last draw
  int py; // signed destination y of last draw
  int hits; // pixels the device would write
  int src_step; // source bits from one text line to the next
  logic [3:0] tick; // stall pattern
  assign cs_ready = !slow || tick[1]; // stalls half the time when slow
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tick <= 4'h0;
    end else begin
      tick <= tick + 4'h1;
    end
  end
  // device action on a finished packet: persistent state and draw effects
  task automatic act;
    int cl;
    int cr;
    int ct;
    int cb;
    int x2;
    int pitch;
    int bpp;
    int col;
    int row;
    logic [31:0] fg;
    if (hop == 7'h01 || hop == 7'h11) begin
      setup_ctrl = words[1];
      clip_tl = words[2];
      clip_br = words[3];
      dest_base = words[4];
      fg_color = words[6];
      if (hop == 7'h11) mono_pat = {words[8], words[7]};
    end
    if (hop == 7'h03) begin
      clip_tl = words[1];
      clip_br = words[2];
    end
    cl = int'(clip_tl[14:0]);
    cr = int'(clip_br[14:0]);
    ct = int'(clip_tl[30:16]);
    cb = int'(clip_br[30:16]);
    bpp = (setup_ctrl[25:24] == 2'b00) ? 1 : (setup_ctrl[25:24] == 2'b11) ? 4 : 2;
    fg = (bpp == 1) ? {24'h00_0000, fg_color[7:0]} : (bpp == 2) ? {16'h0000, fg_color[15:0]} : fg_color;
    pitch = int'($signed(setup_ctrl[15:0])) * (words[0][11] ? 512 : 1);
    px = int'($signed(words[1][15:0]));
    py = int'($signed(words[1][31:16]));
    x2 = int'($signed(words[2][15:0]));
    // pixel: all four clip tests, then base plus y pitch plus x width
    if (hop == 7'h24 && px >= cl && px < cr && py >= ct && py < cb) begin
      hits++;
      pix_addr = dest_base + 32'(py * pitch + px * bpp);
      pix_val = fg;
    end
    // scanline: clip columns and destination span only, seeded pattern
    if (hop == 7'h25) begin
      row = (py + int'(words[0][10:8])) & 7;
      for (int x = px; x < x2 && x < px + 1024; x++) begin
        col = (x + int'(words[0][14:12])) & 7;
        if (x >= cl && x < cr && (setup_ctrl[31] || mono_pat[row * 8 + col] || !setup_ctrl[28])) begin
          hits++;
        end
      end
    end
    // text: next source line on the next bit or the next byte
    if (hop == 7'h26 || hop == 7'h31) begin
      src_step = words[0][16] ? ((x2 - px + 7) / 8) * 8 : x2 - px;
      src_keep_bg = !setup_ctrl[29];
    end
  endtask
  // take words, route by client, keep setup state
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      nw = 0;
      npk = 0;
      first = 1'b1;
      routed = 1'b0;
      hop = 7'h00;
      setup_ctrl = 32'h0000_0000;
      hits = 0;
    end else if (cs_in.valid && cs_ready) begin
      if (first) begin
        nw = 0;
        hop = cs_in.data[28:22];
        routed = (cs_in.data[31:29] == 3'h2);
      end
      if (nw < 16) words[nw] = cs_in.data;
      nw = nw + 1;
      first = cs_in.last;
      if (cs_in.last && routed) begin
        act();
        npk = npk + 1;
      end
    end
  end
endmodule

// [tb.sv]
// testbench driving the issuer through its register port
`timescale 1ns/1ps
`include "bxy_cfg.svh"
module tb;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic slow = 1'b0;
  logic cs_ready;
  logic [31:0] rd_data_q;
  bxy_pkg::bxy_word_t cs_out_q;
  logic [31:0] ctrl0 = 32'h0300_0040; // depth 32 bit, positive pitch
  int bad_count = 0;
  int checked = 0;
  always #4 mclk = ~mclk;
  bxy_issuer dut (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rd_data_q(rd_data_q), .cs_out_q(cs_out_q), .cs_ready(cs_ready));
  bxy_far far (.mclk(mclk), .rstn(rstn), .cs_in(cs_out_q), .slow(slow), .cs_ready(cs_ready));
  task complete_run;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] exp, input logic [31:0] got, input string what);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [31:0] sv(input int k);
    return (k == 0) ? ctrl0 : (32'hC0DE_8000 | k);
  endfunction
  // slot value as it must appear on the stream
  function automatic logic [31:0] mw(input int k);
    return (k == 1 || k == 2) ? (sv(k) & 32'h7FFF_7FFF) : (k == 6) ? (sv(k) & 32'h07FF_FFC0) : sv(k);
  endfunction
  function automatic logic [31:0] hd(input logic [6:0] op, input logic [7:0] len);
    return {3'h2, op, 14'h0000, len};
  endfunction
  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task rreg(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(exp, rd_data_q, what);
  endtask
  // start a kind and compare the packet it streams
  task automatic pk(input logic [2:0] kind, input logic [31:0] hdr, input int n, input logic [39:0] sl);
    int p;
    int w;
    p = far.npk;
    w = 0;
    wreg(`BXY_OFF_CTRL, 32'h0000_0100 | kind);
    while (far.npk == p && w < 200) begin
      @(posedge mclk);
      w++;
    end
    if (w == 200) begin
      bad_count++;
      $display("unexpected packet timeout expected 1 seen 0");
      complete_run;
    end
    repeat (2) @(posedge mclk);
    chk(n + 1, far.nw, "word count");
    chk(hdr, far.words[0], "header");
    for (int k = 0; k < n; k++) chk(mw(sl[39 - 5 * k -: 5]), far.words[k + 1], "body word");
  endtask
  // start a kind that must be refused with the given status
  task automatic rf(input logic [2:0] kind, input logic [31:0] st);
    int p;
    p = far.npk;
    wreg(`BXY_OFF_CTRL, 32'h0000_0100 | kind);
    repeat (6) @(posedge mclk);
    chk(p, far.npk, "refused packets");
    rreg(`BXY_OFF_STATUS, st, "status");
    wreg(`BXY_OFF_STATUS, 32'h0000_003E);
  endtask
  task s_setup;
    slow <= 1'b1;
    pk(3'h0, hd(7'h01, 8'h06), 7, {5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h00});
    slow <= 1'b0;
  endtask
  task s_draws;
    wreg(`BXY_OFF_OPT, 32'h0030_0000);
    pk(3'h1, hd(7'h11, 8'h07) | 32'h0030_0000, 8,
      {5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07, 5'h08});
    pk(3'h2, hd(7'h03, 8'h01), 2, {5'h01, 5'h02, 30'h0});
    pk(3'h3, hd(7'h24, 8'h00), 1, {5'h09, 35'h0});
    wreg(`BXY_OFF_OPT, 32'h0000_5300);
    pk(3'h4, hd(7'h25, 8'h01) | 32'h0000_5300, 2, {5'h09, 5'h0A, 30'h0});
    wreg(`BXY_OFF_OPT, 32'h0001_0000);
    pk(3'h5, hd(7'h26, 8'h02) | 32'h0001_0000, 3, {5'h09, 5'h0A, 5'h0B, 25'h0});
    wreg(`BXY_OFF_OPT, 32'h0000_0000);
    pk(3'h6, hd(7'h31, 8'h05), 6, {5'h09, 5'h0A, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 10'h0});
    rreg(`BXY_OFF_CTRL, 32'h0000_0006, "last kind");
    rreg(`BXY_OFF_CNT, 32'h0000_0004, "inline count");
    rreg(8'h34, 32'hC0DE_8009, "slot read");
  endtask
  task s_refuse;
    wreg(`BXY_OFF_CNT, 32'h0000_0003);
    rf(3'h6, 32'h0000_0012);
    wreg(`BXY_OFF_CNT, 32'h0000_0004);
    rf(3'h7, 32'h0000_0022);
    wreg(`BXY_OFF_OPT, 32'h0000_0800);
    rf(3'h0, 32'h0000_000A);
    wreg(`BXY_OFF_OPT, 32'h0000_0000);
  endtask
  task s_pitch;
    ctrl0 = 32'h0300_8040;
    wreg(`BXY_OFF_SLOT0, ctrl0);
    pk(3'h0, hd(7'h01, 8'h06), 7, {5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h00});
    rf(3'h3, 32'h0000_0046);
    ctrl0 = 32'h0300_0040;
    wreg(`BXY_OFF_SLOT0, ctrl0);
    pk(3'h0, hd(7'h01, 8'h06), 7, {5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h00});
    rreg(`BXY_OFF_STATUS, 32'h0000_0000, "status after fix");
    rreg(8'hFC, 32'h0000_0000, "unmapped read");
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    for (int k = 0; k < 20; k++) wreg(8'(`BXY_OFF_SLOT0 + 4 * k), sv(k));
    wreg(`BXY_OFF_CNT, 32'h0000_0004);
    s_setup();
    s_draws();
    s_refuse();
    s_pitch();
    complete_run;
  end
endmodule
